// File: design/mmc_ctrl.sv
// management control and status of a pluggable four-lane module
// assumes a two-wire engine on link_clk that hands byte accesses and a stop strobe
`timescale 1ns/1ps
module mmc_ctrl
    import mmc_pkg::*;
#(
    parameter int INIT_CYCLES = mmc_pkg::T_INIT_CYCLES,
    parameter int WAKE_CYCLES = mmc_pkg::T_PDOWN_EXIT_CYCLES
) (
    // core clock and power-on reset
    input wire logic core_clk,
    input wire logic rst_n,
    // host pins
    input wire logic module_reset_n,
    input wire logic module_select_n,
    input wire logic low_power_request,
    output logic interrupt_n,
    // lane conditions from the optics
    input wire logic [mmc_pkg::LANES-1:0] rx_los,
    input wire logic [mmc_pkg::LANES-1:0] tx_fault,
    // status
    output logic fully_functional,
    output logic low_power_active,
    output logic data_not_ready,
    // link side, on the two-wire engine clock
    input wire logic link_clk,
    input wire logic link_req,
    input wire mmc_pkg::mmc_link_req_t link_cmd,
    input wire logic link_stop,
    output logic link_ack,
    output logic [7:0] link_rdata
);
    import mmc_pkg::*;

    if (INIT_CYCLES <= DONE_SLACK || INIT_CYCLES >= (1 << CNT_W)) begin : g_chk_init
        $error("INIT_CYCLES out of range");
    end
    if (WAKE_CYCLES <= DONE_SLACK || WAKE_CYCLES >= (1 << CNT_W)) begin : g_chk_wake
        $error("WAKE_CYCLES out of range");
    end

    typedef enum logic [2:0] {
        ST_HOLD,
        ST_INIT,
        ST_READY,
        ST_LOWPWR,
        ST_WAKE
    } mmc_state_t;

    // end count of a timed phase, leaving room for the output flops
    function automatic logic [CNT_W-1:0] phase_end(input int cycles);
        phase_end = CNT_W'(cycles - DONE_SLACK);
    endfunction

    // ---------------- core domain ----------------

    logic [PIN_W-1:0] pin_mid;
    logic [PIN_W-1:0] pin_last;
    logic [PIN_W-1:0] pin_reg;
    logic [1:0] ltog_q;
    logic [1:0] ltog_unused;

    // pins pass three flops; a change counts once the last two agree
    mmc_sync #(.WIDTH(PIN_W), .STAGES(3), .RST_VAL(PIN_RST)) u_pin_sync (
        .clk(core_clk),
        .rst_n(rst_n),
        .d({tx_fault, rx_los, low_power_request, module_select_n, module_reset_n}),
        .q_prev(pin_mid),
        .q(pin_last)
    );

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_reg <= PIN_RST;
        end else if (pin_mid == pin_last) begin
            pin_reg <= pin_last;
        end
    end

    logic mrst_n_s;
    logic sel_n_s;
    logic lp_pin_s;
    logic [7:0] cond_s;
    assign mrst_n_s = pin_reg[0];
    assign sel_n_s = pin_reg[1];
    assign lp_pin_s = pin_reg[2];
    assign cond_s = pin_reg[PIN_W-1:3];

    // module reset pulse width qualification
    logic [RST_CNT_W-1:0] rst_low_cnt_reg;
    logic mod_reset_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_low_cnt_reg <= '0;
            mod_reset_reg <= 1'b0;
        end else if (mrst_n_s) begin
            rst_low_cnt_reg <= '0;
            mod_reset_reg <= 1'b0;
        end else if (rst_low_cnt_reg == RST_CNT_W'(T_RESET_MIN_CYCLES)) begin
            mod_reset_reg <= 1'b1;
        end else begin
            rst_low_cnt_reg <= rst_low_cnt_reg + 1'b1;
        end
    end

    // transactions from the link: toggle in, toggle back
    mmc_xfer_t xfer_hold_reg;
    logic xfer_tog_reg;
    logic xfer_ack_reg;
    logic snap_ack_reg;
    logic snap_tog_reg;
    mmc_snap_t snap_reg;

    mmc_sync #(.WIDTH(2), .STAGES(2), .RST_VAL(2'b00)) u_ltog_sync (
        .clk(core_clk),
        .rst_n(rst_n),
        .d({snap_ack_reg, xfer_tog_reg}),
        .q_prev(ltog_unused),
        .q(ltog_q)
    );

    logic xfer_apply;
    assign xfer_apply = (ltog_q[0] != xfer_ack_reg);

    logic [7:0] mask_core_reg;
    logic pdown_core_reg;

    // hold register stays stable until the ack toggle returns
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            xfer_ack_reg <= 1'b0;
            mask_core_reg <= MASK_RST;
            pdown_core_reg <= CONTROL_RST[CONTROL_PDOWN_BIT];
        end else if (xfer_apply) begin
            xfer_ack_reg <= ~xfer_ack_reg;
            if (xfer_hold_reg.mask_wr) begin
                mask_core_reg <= xfer_hold_reg.mask;
            end
            if (xfer_hold_reg.ctl_wr) begin
                pdown_core_reg <= xfer_hold_reg.ctl[CONTROL_PDOWN_BIT];
            end
        end
    end

    // power state machine
    mmc_state_t state_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic lp_want;
    assign lp_want = lp_pin_s | pdown_core_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_INIT;
            cnt_reg <= '0;
        end else if (mod_reset_reg) begin
            state_reg <= ST_HOLD;
            cnt_reg <= '0;
        end else begin
            case (state_reg)
                ST_HOLD: begin
                    state_reg <= ST_INIT;
                    cnt_reg <= '0;
                end
                ST_INIT: begin
                    if (cnt_reg == phase_end(INIT_CYCLES)) begin
                        state_reg <= ST_READY;
                        cnt_reg <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                ST_READY: begin
                    if (lp_want) begin
                        state_reg <= ST_LOWPWR;
                    end
                end
                ST_LOWPWR: begin
                    if (!lp_want) begin
                        state_reg <= ST_WAKE;
                        cnt_reg <= '0;
                    end
                end
                ST_WAKE: begin
                    if (lp_want) begin
                        state_reg <= ST_LOWPWR;
                    end else if (cnt_reg == phase_end(WAKE_CYCLES)) begin
                        state_reg <= ST_READY;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                default: begin
                    state_reg <= ST_INIT;
                    cnt_reg <= '0;
                end
            endcase
        end
    end

    logic init_done;
    assign init_done = (state_reg == ST_INIT) && (cnt_reg == phase_end(INIT_CYCLES));

    // flags: set on a rising condition, cleared by the read that reported them
    logic [7:0] cond_prev_reg;
    logic [7:0] flags_reg;
    logic ready_flag_reg;
    logic dnr_reg;
    logic serial_ready_reg;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic ready_clr;

    assign flag_set = cond_s & ~cond_prev_reg;
    assign flag_clr = xfer_apply ? xfer_hold_reg.clr_flags : 8'h00;
    assign ready_clr = xfer_apply & xfer_hold_reg.clr_ready;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cond_prev_reg <= 8'h00;
            flags_reg <= 8'h00;
        end else if (state_reg == ST_HOLD || mod_reset_reg) begin
            cond_prev_reg <= 8'h00;
            flags_reg <= 8'h00;
        end else begin
            cond_prev_reg <= cond_s;
            // a new event wins over a clear in the same cycle
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_flag_reg <= 1'b0;
            dnr_reg <= 1'b1;
            serial_ready_reg <= 1'b0;
        end else if (state_reg == ST_HOLD || mod_reset_reg) begin
            ready_flag_reg <= 1'b0;
            dnr_reg <= 1'b1;
            serial_ready_reg <= 1'b0;
        end else if (init_done) begin
            ready_flag_reg <= 1'b1;
            dnr_reg <= 1'b0;
            serial_ready_reg <= 1'b1;
        end else if (ready_clr) begin
            ready_flag_reg <= 1'b0;
        end
    end

    // state snapshot for the link; reloaded each time the link has taken the last one
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            snap_tog_reg <= 1'b0;
            snap_reg <= '0;
        end else if (ltog_q[1] == snap_tog_reg) begin
            snap_tog_reg <= ~snap_tog_reg;
            snap_reg.respond <= serial_ready_reg & ~sel_n_s;
            snap_reg.dnr <= dnr_reg;
            snap_reg.ready_flag <= ready_flag_reg;
            snap_reg.flags <= flags_reg;
        end
    end

    // outputs, all from flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_n <= 1'b1;
            fully_functional <= 1'b0;
            low_power_active <= 1'b0;
            data_not_ready <= 1'b1;
        end else begin
            interrupt_n <= ~((|(flags_reg & ~mask_core_reg)) | ready_flag_reg);
            fully_functional <= (state_reg == ST_READY);
            low_power_active <= (state_reg == ST_LOWPWR) || (state_reg == ST_READY && lp_want);
            data_not_ready <= dnr_reg;
        end
    end

    // ---------------- link domain ----------------

    logic [2:0] ctog_q;
    logic [2:0] ctog_unused;

    mmc_sync #(.WIDTH(3), .STAGES(2), .RST_VAL(3'b000)) u_ctog_sync (
        .clk(link_clk),
        .rst_n(rst_n),
        .d({1'b0, snap_tog_reg, xfer_ack_reg}),
        .q_prev(ctog_unused),
        .q(ctog_q)
    );

    mmc_snap_t snap_l_reg;
    logic [7:0] mask_l_reg;
    logic [7:0] ctl_l_reg;
    mmc_xfer_t acc_reg;
    mmc_xfer_t acc_next;
    logic link_busy;
    logic accept;

    // a new frame is refused until the core has taken the previous one
    assign link_busy = (xfer_tog_reg != ctog_q[0]);
    assign accept = link_req & snap_l_reg.respond & ~link_busy;

    function automatic logic [7:0] read_byte(input logic [7:0] addr, input mmc_snap_t s,
                                             input logic [7:0] m, input logic [7:0] c);
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            ADDR_STATUS: begin
                v[STATUS_DNR_BIT] = s.dnr;
                v[STATUS_READY_FLAG_BIT] = s.ready_flag;
            end
            ADDR_FLAGS: v = s.flags;
            ADDR_MASK: v = m;
            ADDR_CONTROL: v = c;
            default: v = 8'h00;
        endcase
        read_byte = v;
    endfunction

    // only what was actually reported is cleared at the stop
    always_comb begin
        acc_next = acc_reg;
        if (accept) begin
            if (link_cmd.write) begin
                if (link_cmd.addr == ADDR_MASK) begin
                    acc_next.mask_wr = 1'b1;
                    acc_next.mask = link_cmd.wdata;
                end
                if (link_cmd.addr == ADDR_CONTROL) begin
                    acc_next.ctl_wr = 1'b1;
                    acc_next.ctl = link_cmd.wdata;
                end
            end else begin
                if (link_cmd.addr == ADDR_FLAGS) begin
                    acc_next.clr_flags = acc_reg.clr_flags | snap_l_reg.flags;
                end
                if (link_cmd.addr == ADDR_STATUS) begin
                    acc_next.clr_ready = acc_reg.clr_ready | snap_l_reg.ready_flag;
                end
            end
        end
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_ack <= 1'b0;
            link_rdata <= 8'h00;
            mask_l_reg <= MASK_RST;
            ctl_l_reg <= CONTROL_RST;
        end else begin
            link_ack <= accept;
            link_rdata <= (accept && !link_cmd.write) ?
                read_byte(link_cmd.addr, snap_l_reg, mask_l_reg, ctl_l_reg) : 8'h00;
            if (accept && link_cmd.write && link_cmd.addr == ADDR_MASK) begin
                mask_l_reg <= link_cmd.wdata;
            end
            if (accept && link_cmd.write && link_cmd.addr == ADDR_CONTROL) begin
                ctl_l_reg <= link_cmd.wdata;
            end
        end
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= '0;
            xfer_hold_reg <= '0;
            xfer_tog_reg <= 1'b0;
        end else if (link_stop) begin
            acc_reg <= '0;
            if (acc_next != '0 && !link_busy) begin
                xfer_hold_reg <= acc_next;
                xfer_tog_reg <= ~xfer_tog_reg;
            end
        end else begin
            acc_reg <= acc_next;
        end
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            snap_l_reg <= '0;
            snap_ack_reg <= 1'b0;
        end else if (ctog_q[1] != snap_ack_reg) begin
            snap_l_reg <= snap_reg;
            snap_ack_reg <= ~snap_ack_reg;
        end
    end
endmodule

// File: design/mmc_pkg.sv
// constants, field layouts and carrier types of the module management block
// assumes a 100 MHz core clock and a byte-wide link access port on its own clock
package mmc_pkg;
    // core clock rate
    localparam int CORE_MHZ = 100;

    // time limits as printed
    localparam int T_INIT_MS = 2000;
    localparam int T_SERIAL_MS = 2000;
    localparam int T_DATA_MS = 2000;
    localparam int T_RESET_MIN_US = 2;
    localparam int T_LOW_POWER_REQUEST_US = 100;
    localparam int T_PDOWN_EXIT_MS = 300;

    // derived cycle counts (longest times round down, least time rounds up)
    localparam int T_INIT_CYCLES = T_INIT_MS * 1000 * CORE_MHZ;
    localparam int T_RESET_MIN_CYCLES = T_RESET_MIN_US * CORE_MHZ;
    localparam int T_PDOWN_EXIT_CYCLES = T_PDOWN_EXIT_MS * 1000 * CORE_MHZ;
    localparam int T_LOW_POWER_REQUEST_CYCLES = T_LOW_POWER_REQUEST_US * CORE_MHZ;

    // counter widths and margins
    localparam int CNT_W = 28;
    localparam int RST_CNT_W = 12;
    localparam int DONE_SLACK = 4;

    // lanes and flag byte layout
    localparam int LANES = 4;
    localparam int RX_LOS_LSB = 0;
    localparam int TX_FAULT_LSB = 4;

    // link byte addresses
    localparam logic [7:0] ADDR_STATUS = 8'h02;
    localparam logic [7:0] ADDR_FLAGS = 8'h03;
    localparam logic [7:0] ADDR_CONTROL = 8'h5d;
    localparam logic [7:0] ADDR_MASK = 8'h64;

    // bit positions
    localparam int STATUS_DNR_BIT = 0;
    localparam int STATUS_READY_FLAG_BIT = 1;
    localparam int CONTROL_PDOWN_BIT = 0;

    // reset values
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    // pin order: {tx_fault[3:0], rx_los[3:0], low_power_request, module_select_n, module_reset_n}
    localparam int PIN_W = 3 + 2 * LANES;
    localparam logic [10:0] PIN_RST = 11'h003;

    // one byte access from the two-wire engine
    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mmc_link_req_t;

    // effects of one finished transaction, handed to the core at the stop bit
    typedef struct packed {
        logic mask_wr;
        logic [7:0] mask;
        logic ctl_wr;
        logic [7:0] ctl;
        logic [7:0] clr_flags;
        logic clr_ready;
    } mmc_xfer_t;

    // core state seen by the link side
    typedef struct packed {
        logic respond;
        logic dnr;
        logic ready_flag;
        logic [7:0] flags;
    } mmc_snap_t;
endpackage

// File: design/mmc_sync.sv
// multi-stage synchroniser for a vector of levels or toggles
// assumes d is quiet or changes slowly relative to clk
`timescale 1ns/1ps
module mmc_sync #(
    parameter int WIDTH = 1,
    parameter int STAGES = 2,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q_prev,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage_reg [STAGES];

    if (STAGES < 2) begin : g_chk
        $error("mmc_sync needs at least two stages");
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < STAGES; i++) begin
                stage_reg[i] <= RST_VAL;
            end
        end else begin
            stage_reg[0] <= d;
            for (int i = 1; i < STAGES; i++) begin
                stage_reg[i] <= stage_reg[i-1];
            end
        end
    end

    // q_prev is the first stage only for a two-stage chain, left unread by those callers; only the three-stage pin filter reads it
    assign q_prev = stage_reg[STAGES-2];
    assign q = stage_reg[STAGES-1];
endmodule

// File: verification/mmc_ctrl_bench.sv
// self-checking bench for the management block driven through a host model
// assumes shortened init and wake counts; core 10 ns, link 15 ns
`timescale 1ns/1ps
module mmc_ctrl_bench;
    import mmc_pkg::*;
    localparam int INIT = 200;
    localparam int WAKE = 100;
    logic core_clk, rst_n, module_reset_n, module_select_n, low_power_request;
    logic [LANES-1:0] rx_los, tx_fault;
    logic interrupt_n, fully_functional, low_power_active, data_not_ready;
    logic link_clk, link_req, link_stop, link_ack;
    mmc_link_req_t link_cmd;
    logic [7:0] link_rdata;
    int num_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    mmc_ctrl #(.INIT_CYCLES(INIT), .WAKE_CYCLES(WAKE)) i_mmc_ctrl (.core_clk, .rst_n, .module_reset_n,
        .module_select_n, .low_power_request, .interrupt_n, .rx_los, .tx_fault, .fully_functional,
        .low_power_active, .data_not_ready, .link_clk, .link_req, .link_cmd, .link_stop, .link_ack, .link_rdata);
    mmc_host_model i_mmc_host_model (.link_clk, .link_req, .link_cmd, .link_stop, .link_ack, .link_rdata);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic pin(input string name, input logic got, input logic exp);
        chk(name, {7'h00, got}, {7'h00, exp});
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            test_done();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wait_up(input int n);
        for (int i = 0; i < n && !(fully_functional === 1'b1 && low_power_active === 1'b0); i++) step(1);
        step(4);
    endtask
    // frame plus settle time for clears and interrupt release
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic eok,
                       input logic [7:0] eq);
        logic ok;
        logic [7:0] q;
        i_mmc_host_model.xfer(wr, a, d, ok, q);
        pin("link ack", ok, eok);
        if (eok && !wr) chk("link read", q, eq);
        step(12);
    endtask
    initial begin
        rst_n = 1'b0;
        module_reset_n = 1'b1;
        module_select_n = 1'b0;
        low_power_request = 1'b0;
        rx_los = '0;
        tx_fault = '0;
        repeat (4) @(posedge core_clk);
        #1;
        pin("interrupt_n", interrupt_n, 1'b1);
        pin("data_not_ready", data_not_ready, 1'b1);
        rst_n = 1'b1;
        acc(1'b0, ADDR_STATUS, 8'h00, 1'b0, 8'h00);
        wait_up(INIT + 10);
        pin("fully_functional", fully_functional, 1'b1);
        pin("data_not_ready", data_not_ready, 1'b0);
        pin("interrupt_n", interrupt_n, 1'b0);
        acc(1'b0, ADDR_STATUS, 8'h00, 1'b1, 8'h02);
        pin("interrupt_n", interrupt_n, 1'b1);
        acc(1'b0, 8'h40, 8'h00, 1'b1, 8'h00);
        for (int i = 0; i < 8; i++) begin
            {tx_fault, rx_los} = 8'h01 << i;
            step(12);
            pin("interrupt_n", interrupt_n, 1'b0);
            acc(1'b0, ADDR_FLAGS, 8'h00, 1'b1, 8'h01 << i);
            pin("interrupt_n", interrupt_n, 1'b1);
            {tx_fault, rx_los} = 8'h00;
            step(6);
        end
        acc(1'b1, ADDR_MASK, 8'h01, 1'b1, 8'h00);
        acc(1'b0, ADDR_MASK, 8'h00, 1'b1, 8'h01);
        rx_los = 4'h1;
        step(12);
        pin("interrupt_n", interrupt_n, 1'b1);
        acc(1'b1, ADDR_MASK, 8'h00, 1'b1, 8'h00);
        pin("interrupt_n", interrupt_n, 1'b0);
        acc(1'b0, ADDR_FLAGS, 8'h00, 1'b1, 8'h01);
        pin("interrupt_n", interrupt_n, 1'b1);
        rx_los = 4'h0;
        module_select_n = 1'b1;
        step(100);
        acc(1'b0, ADDR_STATUS, 8'h00, 1'b0, 8'h00);
        module_select_n = 1'b0;
        step(20);
        acc(1'b0, ADDR_STATUS, 8'h00, 1'b1, 8'h00);
        low_power_request = 1'b1;
        step(10);
        pin("low_power_active", low_power_active, 1'b1);
        low_power_request = 1'b0;
        wait_up(WAKE + 20);
        pin("fully_functional", fully_functional, 1'b1);
        acc(1'b1, ADDR_CONTROL, 8'h01, 1'b1, 8'h00);
        pin("low_power_active", low_power_active, 1'b1);
        acc(1'b0, ADDR_CONTROL, 8'h00, 1'b1, 8'h01);
        acc(1'b1, ADDR_CONTROL, 8'h00, 1'b1, 8'h00);
        wait_up(WAKE + 20);
        pin("fully_functional", fully_functional, 1'b1);
        pin("low_power_active", low_power_active, 1'b0);
        module_reset_n = 1'b0;
        step(100);
        module_reset_n = 1'b1;
        step(10);
        pin("fully_functional", fully_functional, 1'b1);
        module_reset_n = 1'b0;
        step(250);
        pin("data_not_ready", data_not_ready, 1'b1);
        pin("fully_functional", fully_functional, 1'b0);
        module_reset_n = 1'b1;
        step(INIT - 20);
        pin("fully_functional", fully_functional, 1'b0);
        wait_up(40);
        pin("fully_functional", fully_functional, 1'b1);
        pin("interrupt_n", interrupt_n, 1'b0);
        test_done();
    end
endmodule

// File: verification/mmc_ctrl_properties.sv
// timing and gating properties on the management block's pins and link port
// assumes binding to mmc_ctrl; link clock unrelated to the core clock
`timescale 1ns/1ps
module mmc_ctrl_properties
    import mmc_pkg::*;
#(
    parameter int INIT_CYCLES = mmc_pkg::T_INIT_CYCLES,
    parameter int WAKE_CYCLES = mmc_pkg::T_PDOWN_EXIT_CYCLES
) (
    // core side
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic module_reset_n,
    input wire logic module_select_n,
    input wire logic low_power_request,
    input wire logic interrupt_n,
    input wire logic [mmc_pkg::LANES-1:0] rx_los,
    input wire logic [mmc_pkg::LANES-1:0] tx_fault,
    input wire logic fully_functional,
    input wire logic low_power_active,
    input wire logic data_not_ready,
    // link side
    input wire logic link_clk,
    input wire logic link_req,
    input wire mmc_pkg::mmc_link_req_t link_cmd,
    input wire logic link_stop,
    input wire logic link_ack,
    input wire logic [7:0] link_rdata
);
    logic [8:0] desel_cnt;
    logic [8:0] rlow_cnt;
    logic [31:0] wait_cnt;
    // saturating, so long deselects do not wrap into false passes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) desel_cnt <= '0;
        else if (!module_select_n) desel_cnt <= '0;
        else if (!desel_cnt[8]) desel_cnt <= desel_cnt + 9'h001;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) rlow_cnt <= '0;
        else if (module_reset_n) rlow_cnt <= '0;
        else if (!rlow_cnt[8]) rlow_cnt <= rlow_cnt + 9'h001;
    end
    // low power phases restart the wait rather than extend the bound
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) wait_cnt <= '0;
        else if (fully_functional || low_power_active || low_power_request || !module_reset_n) wait_cnt <= '0;
        else wait_cnt <= wait_cnt + 32'h1;
    end
    a_ack_needs_req: assert property (@(posedge link_clk) disable iff (!rst_n)
        link_ack |-> $past(link_req)) else $error("ack without request");
    a_rdata_idle: assert property (@(posedge link_clk) disable iff (!rst_n)
        !link_ack |-> link_rdata == 8'h00) else $error("read data outside ack");
    a_desel_quiet: assert property (@(posedge link_clk) disable iff (!rst_n)
        link_ack |-> desel_cnt < 9'd100) else $error("ack while deselected");
    a_lp_enter: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(low_power_request) && module_reset_n && fully_functional |-> ##[1:10] low_power_active)
        else $error("low power late");
    a_ready_dnr: assert property (@(posedge core_clk) disable iff (!rst_n)
        fully_functional |-> !data_not_ready) else $error("ready with data not ready");
    a_int_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(interrupt_n) |-> !data_not_ready) else $error("interrupt before data ready");
    a_reset_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        rlow_cnt > 9'd210 |-> data_not_ready && interrupt_n && !fully_functional) else $error("reset not held");
    a_init_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
        wait_cnt < INIT_CYCLES + 16) else $error("initialization too slow");
endmodule
bind mmc_ctrl mmc_ctrl_properties #(.INIT_CYCLES(INIT_CYCLES), .WAKE_CYCLES(WAKE_CYCLES)) i_mmc_ctrl_properties (
    .core_clk, .rst_n, .module_reset_n, .module_select_n, .low_power_request, .interrupt_n, .rx_los,
    .tx_fault, .fully_functional, .low_power_active, .data_not_ready, .link_clk, .link_req, .link_cmd,
    .link_stop, .link_ack, .link_rdata);

// File: verification/mmc_host_model.sv
// host side model of the two-wire engine: byte accesses and stop strobes
// assumes the link clock runs only during frames, as a real bus master does
`timescale 1ns/1ps
module mmc_host_model
    import mmc_pkg::*;
(
    // link port
    output logic link_clk,
    output logic link_req,
    output mmc_pkg::mmc_link_req_t link_cmd,
    output logic link_stop,
    input wire logic link_ack,
    input wire logic [7:0] link_rdata
);
    initial begin
        link_clk = 1'b0;
        link_req = 1'b0;
        link_cmd = '0;
        link_stop = 1'b0;
    end
    // moves to just after the next rising edge
    task automatic tick();
        #6.5 link_clk = 1'b0;
        #7.5 link_clk = 1'b1;
        #1;
    endtask
    // one frame with a single byte access
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic ok,
                        output logic [7:0] q);
        repeat (10) tick(); // address phase refreshes the select view
        link_cmd = '{write: wr, addr: a, wdata: d};
        link_req = 1'b1;
        tick();
        link_req = 1'b0;
        link_cmd = ~link_cmd; // released lines do not keep the last value
        ok = link_ack;
        q = link_rdata;
        tick();
        link_stop = 1'b1;
        tick();
        link_stop = 1'b0;
        repeat (8) tick(); // spacing before the next frame
    endtask
endmodule
